// >>> inc/core_exec_cfg.svh
/*
 * Constants of the core execute subset: opcode patterns, field positions,
 * register offsets and reset values.
 * Assumes a 14-bit instruction word and a 13-bit program counter.
 */
`ifndef CORE_EXEC_CFG_SVH
`define CORE_EXEC_CFG_SVH

// Instruction word, program counter, data and file address widths
`define INSTR_W          14
`define PC_W             13
`define DATA_W           8
`define FADDR_W          7

// Field positions
`define F_ADDR_LSB       0
`define F_DEST_BIT       7
`define F_BSEL_LSB       7
`define F_LIT_W          11
`define LATCH_HI         4
`define LATCH_LO         3
`define LATCH_W          5

// Opcode patterns, matched under the masks beside them; OPV_WDKICK has no mask and is matched whole
`define OPM_BITSKIP      14'h3C00
`define OPV_BITSKIP      14'h1C00
`define OPM_CALL         14'h3800
`define OPV_CALL         14'h2000
`define OPM_FIELD6       14'h3F00
`define OPV_INVERT       14'h0900
`define OPV_DECR         14'h0300
`define OPM_FIELD7       14'h3F80
`define OPV_FZERO        14'h0180
`define OPV_AZERO        14'h0100
`define OPV_WDKICK       14'h0064

// Register port offsets
`define RADDR_W          4
`define RDATA_W          16
`define REG_LATCH        4'h0
`define REG_STATUS       4'h1
`define REG_ACCUM        4'h2
`define REG_PC           4'h3
`define REG_STACK_TOP    4'h4

// Status bit positions
`define ST_ZERO          0
`define ST_EXPIRY_N      1
`define ST_SLEEP_N       2
`define ST_FLUSH         3

// Reset values
`define RST_PC           13'h0000
`define RST_ACCUM        8'h00
`define RST_LATCH        5'h00
`define WDT_CLEAR_VAL    8'h00

`endif

// >>> inc/core_exec_pkg.sv
/*
 * Types of the core execute subset.
 * Assumes core_exec_cfg.svh is on the include path.
 */
`include "core_exec_cfg.svh"

package core_exec_pkg;

    // Execute cycle or the discarded NOP cycle after a branch or skip
    typedef enum logic [0:0] {
        EXEC,
        FLUSH
    } exec_state_e;

    // Decoded operation
    typedef enum logic [2:0] {
        OTHER_OP,
        BIT_SET_SKIP_OP,
        WATCHDOG_KICK_OP,
        CALL_OP,
        FILE_INVERT_OP,
        FILE_ZEROING_OP,
        FILE_DECREMENT_OP,
        ACCUMULATOR_ZEROING_OP
    } op_e;

    // Write towards the register file
    typedef struct packed {
        logic                  we;
        logic [`FADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]    data;
    } file_wr_s;

    // Push towards the return stack
    typedef struct packed {
        logic                  push;
        logic [`PC_W-1:0]      addr;
    } stack_push_s;

endpackage

// >>> rtl/return_stack.sv
/*
 * Circular return stack: a push writes one entry and loads the same value
 * into the top register at the same edge.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`include "core_exec_cfg.svh"

module return_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = `PC_W
) (
    input  wire logic                           I_CLK,
    input  wire logic                           I_RST,
    input  wire core_exec_pkg::stack_push_s     i_push,
    output logic [WIDTH-1:0]                    o_top
);
    localparam int PW = $clog2(DEPTH);

    // Depth must be a power of two so the pointer wraps by itself
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("return_stack: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    ptr_reg;
    logic [PW-1:0]    ptr_next;
    logic [WIDTH-1:0] top_reg;
    logic [WIDTH-1:0] top_next;
    logic             filled_reg;
    logic             filled_next;

    ////////////////////////////////////////////////////////////////////////
    // Pointer and registered top; overflow silently wraps over the oldest
    // Until the first push the top keeps its reset value, since the
    // storage is not reset and would otherwise put unknowns on the top
    always_comb begin
        ptr_next    = ptr_reg;
        filled_next = filled_reg;
        top_next    = filled_reg ? mem[ptr_reg - PW'(1)] : top_reg;
        if (i_push.push) begin
            ptr_next    = ptr_reg + PW'(1);
            filled_next = 1'b1;
            top_next    = i_push.addr[WIDTH-1:0];
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ptr_reg    <= '0;
            top_reg    <= '0;
            filled_reg <= 1'b0;
        end else begin
            ptr_reg    <= ptr_next;
            top_reg    <= top_next;
            filled_reg <= filled_next;
        end
    end

    // Storage has no reset; entries are only read after being pushed
    always_ff @(posedge I_CLK) begin
        if (i_push.push) begin
            mem[ptr_reg] <= i_push.addr[WIDTH-1:0];
        end
    end

    assign o_top = top_reg;

endmodule

// >>> rtl/core_exec_subset.sv
/*
 * Execute stage for a subset of the core instruction set: bit test with
 * skip, watchdog kick, call, complement, decrement, file and accumulator
 * clears. Holds the program counter, accumulator, zero flag and the two
 * active-low watchdog status flags; the register file lives outside.
 * Assumes the fetch side presents the word at O_PC with I_INSTR_VALID,
 * and that I_FILE_RDATA is the register at O_FILE_RADDR in that cycle.
 */
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "core_exec_cfg.svh"

module core_exec_subset #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic                     I_CLK,
    input  wire logic                     I_RST,
    input  wire logic                     I_INSTR_VALID,
    input  wire logic [`INSTR_W-1:0]      I_INSTR,
    input  wire logic [`DATA_W-1:0]       I_FILE_RDATA,
    input  wire logic                     I_WDT_EXPIRED,
    input  wire logic                     I_SLEEP_ENTER,
    input  wire logic [`RADDR_W-1:0]      I_REG_ADDR,
    input  wire logic [`RDATA_W-1:0]      I_REG_WDATA,
    input  wire logic                     I_REG_WR,
    input  wire logic                     I_REG_RD,
    output logic [`RDATA_W-1:0]           O_REG_RDATA,
    output logic [`FADDR_W-1:0]           O_FILE_RADDR,
    output core_exec_pkg::file_wr_s       O_FILE_WR,
    output logic [`PC_W-1:0]              O_PC,
    output logic [`PC_W-1:0]              O_STACK_TOP,
    output logic [`DATA_W-1:0]            O_ACCUM,
    output logic                          O_ZERO,
    output logic                          O_WATCHDOG_EXPIRY_FLAG_N,
    output logic                          O_SLEEP_FLAG_N,
    output logic                          O_WATCHDOG_CLEAR,
    output logic                          O_FLUSH
);

    if (STACK_DEPTH < 2 || STACK_DEPTH > 256) begin : g_chk
        $error("core_exec_subset: STACK_DEPTH out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode, used for the execute path
    function automatic core_exec_pkg::op_e decode(
        input logic [`INSTR_W-1:0] w
    );
        core_exec_pkg::op_e op;
        op = core_exec_pkg::OTHER_OP;
        if ((w & `OPM_BITSKIP) == `OPV_BITSKIP)
            op = core_exec_pkg::BIT_SET_SKIP_OP;
        else if ((w & `OPM_CALL) == `OPV_CALL)
            op = core_exec_pkg::CALL_OP;
        else if (w == `OPV_WDKICK)
            op = core_exec_pkg::WATCHDOG_KICK_OP;
        else if ((w & `OPM_FIELD6) == `OPV_INVERT)
            op = core_exec_pkg::FILE_INVERT_OP;
        else if ((w & `OPM_FIELD6) == `OPV_DECR)
            op = core_exec_pkg::FILE_DECREMENT_OP;
        else if ((w & `OPM_FIELD7) == `OPV_FZERO)
            op = core_exec_pkg::FILE_ZEROING_OP;
        else if ((w & `OPM_FIELD7) == `OPV_AZERO)
            op = core_exec_pkg::ACCUMULATOR_ZEROING_OP;
        return op;
    endfunction

    core_exec_pkg::exec_state_e state_reg;
    core_exec_pkg::exec_state_e state_next;
    core_exec_pkg::op_e         op;
    core_exec_pkg::file_wr_s    fwr_reg;
    core_exec_pkg::file_wr_s    fwr_next;
    core_exec_pkg::stack_push_s push;
    logic [`PC_W-1:0]           pc_reg;
    logic [`PC_W-1:0]           pc_next;
    logic [`DATA_W-1:0]         acc_reg;
    logic [`DATA_W-1:0]         acc_next;
    logic                       zero_reg;
    logic                       zero_next;
    logic                       expiry_n_reg;
    logic                       expiry_n_next;
    logic                       sleep_n_reg;
    logic                       sleep_n_next;
    logic                       kick_reg;
    logic                       kick_next;
    logic [`LATCH_W-1:0]        latch_reg;
    logic [`LATCH_W-1:0]        latch_next;
    logic [`RDATA_W-1:0]        rdata_reg;
    logic [`RDATA_W-1:0]        rdata_next;
    logic [`DATA_W-1:0]         result;
    logic [2:0]                 bsel;
    logic                       dest_file;
    logic                       exec;

    assign exec         = I_INSTR_VALID && state_reg == core_exec_pkg::EXEC;
    assign op           = decode(I_INSTR);
    assign bsel         = I_INSTR[`F_BSEL_LSB +: 3];
    assign dest_file    = I_INSTR[`F_DEST_BIT];
    assign O_FILE_RADDR = I_INSTR[`F_ADDR_LSB +: `FADDR_W];
    assign O_FLUSH      = state_reg == core_exec_pkg::FLUSH;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, program counter and call push
    always_comb begin
        state_next = core_exec_pkg::EXEC;
        pc_next    = pc_reg;
        push.push  = 1'b0;
        push.addr  = pc_reg + `PC_W'(1);
        if (state_reg == core_exec_pkg::FLUSH) begin
            // Discarded slot: a skipped word still occupies one address
            pc_next = pc_reg;
        end else if (I_INSTR_VALID) begin
            pc_next = pc_reg + `PC_W'(1);
            unique case (op)
                core_exec_pkg::BIT_SET_SKIP_OP: begin
                    if (I_FILE_RDATA[bsel]) begin
                        pc_next    = pc_reg + `PC_W'(2);
                        state_next = core_exec_pkg::FLUSH;
                    end
                end
                core_exec_pkg::CALL_OP: begin
                    push.push  = 1'b1;
                    pc_next    = {latch_reg[`LATCH_HI:`LATCH_LO],
                                  I_INSTR[`F_LIT_W-1:0]};
                    state_next = core_exec_pkg::FLUSH;
                end
                default: begin
                end
            endcase
        end
    end

    // Skip target is counted ahead so the flush slot leaves the PC alone
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_reg <= core_exec_pkg::EXEC;
            pc_reg    <= `RST_PC;
        end else begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath: accumulator, zero flag and register file write
    always_comb begin
        acc_next  = acc_reg;
        zero_next = zero_reg;
        fwr_next  = '0;
        result    = '0;
        if (exec) begin
            unique case (op)
                core_exec_pkg::FILE_INVERT_OP: begin
                    result = ~I_FILE_RDATA;
                end
                core_exec_pkg::FILE_DECREMENT_OP: begin
                    result = I_FILE_RDATA - `DATA_W'(1);
                end
                default: begin
                end
            endcase
            unique case (op)
                core_exec_pkg::FILE_INVERT_OP,
                core_exec_pkg::FILE_DECREMENT_OP: begin
                    zero_next = result == '0;
                    if (dest_file) begin
                        fwr_next.we   = 1'b1;
                        fwr_next.addr = O_FILE_RADDR;
                        fwr_next.data = result;
                    end else begin
                        acc_next = result;
                    end
                end
                core_exec_pkg::FILE_ZEROING_OP: begin
                    fwr_next.we   = 1'b1;
                    fwr_next.addr = O_FILE_RADDR;
                    fwr_next.data = '0;
                    zero_next     = 1'b1;
                end
                core_exec_pkg::ACCUMULATOR_ZEROING_OP: begin
                    acc_next  = `RST_ACCUM;
                    zero_next = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            acc_reg  <= `RST_ACCUM;
            zero_reg <= 1'b0;
            fwr_reg  <= '0;
        end else begin
            acc_reg  <= acc_next;
            zero_reg <= zero_next;
            fwr_reg  <= fwr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog kick and active-low status flags
    always_comb begin
        kick_next     = exec && op == core_exec_pkg::WATCHDOG_KICK_OP;
        expiry_n_next = expiry_n_reg;
        sleep_n_next  = sleep_n_reg;
        if (I_WDT_EXPIRED) expiry_n_next = 1'b0;
        if (I_SLEEP_ENTER) sleep_n_next = 1'b0;
        // A kick in the same cycle as an event wins: flags read set
        if (kick_next) begin
            expiry_n_next = 1'b1;
            sleep_n_next  = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            kick_reg     <= 1'b0;
            expiry_n_reg <= 1'b1;
            sleep_n_reg  <= 1'b1;
        end else begin
            kick_reg     <= kick_next;
            expiry_n_reg <= expiry_n_next;
            sleep_n_reg  <= sleep_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port: latch writable, state readable, unmapped reads zero
    always_comb begin
        latch_next = latch_reg;
        rdata_next = '0;
        if (I_REG_WR && I_REG_ADDR == `REG_LATCH) begin
            latch_next = I_REG_WDATA[`LATCH_W-1:0];
        end
        if (I_REG_RD) begin
            unique case (I_REG_ADDR)
                `REG_LATCH:     rdata_next = `RDATA_W'(latch_reg);
                `REG_STATUS: begin
                    rdata_next[`ST_ZERO]     = zero_reg;
                    rdata_next[`ST_EXPIRY_N] = expiry_n_reg;
                    rdata_next[`ST_SLEEP_N]  = sleep_n_reg;
                    rdata_next[`ST_FLUSH]    = O_FLUSH;
                end
                `REG_ACCUM:     rdata_next = `RDATA_W'(acc_reg);
                `REG_PC:        rdata_next = `RDATA_W'(pc_reg);
                `REG_STACK_TOP: rdata_next = `RDATA_W'(O_STACK_TOP);
                default:        rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            latch_reg <= `RST_LATCH;
            rdata_reg <= '0;
        end else begin
            latch_reg <= latch_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Return stack holds the pushed return addresses
    return_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (`PC_W)
    ) u_stack (
        .I_CLK  (I_CLK),
        .I_RST  (I_RST),
        .i_push (push),
        .o_top  (O_STACK_TOP)
    );

    assign O_REG_RDATA              = rdata_reg;
    assign O_FILE_WR                = fwr_reg;
    assign O_PC                     = pc_reg;
    assign O_ACCUM                  = acc_reg;
    assign O_ZERO                   = zero_reg;
    assign O_WATCHDOG_EXPIRY_FLAG_N = expiry_n_reg;
    assign O_SLEEP_FLAG_N           = sleep_n_reg;
    assign O_WATCHDOG_CLEAR         = kick_reg;

endmodule

// >>> verification/core_exec_subset_properties.sv
/*
 * Port-level checks of the core execute subset.
 * Assumes it is bound to core_exec_subset and the config header is found.
 */
`include "core_exec_cfg.svh"

module core_exec_subset_properties (
    input wire logic                     I_CLK,
    input wire logic                     I_RST,
    input wire logic                     I_INSTR_VALID,
    input wire logic [`INSTR_W-1:0]      I_INSTR,
    input wire logic [`DATA_W-1:0]       I_FILE_RDATA,
    input wire logic                     I_WDT_EXPIRED,
    input wire logic                     I_SLEEP_ENTER,
    input wire logic [`RADDR_W-1:0]      I_REG_ADDR,
    input wire logic [`RDATA_W-1:0]      I_REG_WDATA,
    input wire logic                     I_REG_WR,
    input wire logic                     I_REG_RD,
    input wire logic [`RDATA_W-1:0]      O_REG_RDATA,
    input wire logic [`FADDR_W-1:0]      O_FILE_RADDR,
    input wire core_exec_pkg::file_wr_s  O_FILE_WR,
    input wire logic [`PC_W-1:0]         O_PC,
    input wire logic [`PC_W-1:0]         O_STACK_TOP,
    input wire logic [`DATA_W-1:0]       O_ACCUM,
    input wire logic                     O_ZERO,
    input wire logic                     O_WATCHDOG_EXPIRY_FLAG_N,
    input wire logic                     O_SLEEP_FLAG_N,
    input wire logic                     O_WATCHDOG_CLEAR,
    input wire logic                     O_FLUSH
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] hi_pc_reg;
    logic       taken;
    logic       is_skip;
    logic       is_call;
    logic       is_inv;
    logic       is_dec;

    ////////////////////////////////////////////////////////////////////////
    // Shadow of latch bits 4:3, since the latch itself is not at the ports
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            hi_pc_reg <= 2'h0;
        end else if (I_REG_WR && I_REG_ADDR == `REG_LATCH) begin
            hi_pc_reg <= I_REG_WDATA[`LATCH_HI:`LATCH_LO];
        end
    end

    // A word counts only outside the discarded cycle
    assign taken   = I_INSTR_VALID && !O_FLUSH;
    assign is_skip = taken && (I_INSTR & `OPM_BITSKIP) == `OPV_BITSKIP;
    assign is_call = taken && (I_INSTR & `OPM_CALL) == `OPV_CALL;
    assign is_inv  = taken && (I_INSTR & `OPM_FIELD6) == `OPV_INVERT;
    assign is_dec  = taken && (I_INSTR & `OPM_FIELD6) == `OPV_DECR;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    a_call_target: assert property (
        is_call |=> O_FLUSH &&
        O_PC == {$past(hi_pc_reg), $past(I_INSTR[10:0])})
        else $error("call target wrong");
    a_call_push: assert property (
        is_call |=> O_STACK_TOP == $past(O_PC) + 13'h0001)
        else $error("return address wrong");
    a_skip_taken: assert property (
        is_skip && I_FILE_RDATA[I_INSTR[9:7]] |=> O_FLUSH &&
        O_PC == $past(O_PC) + 13'h0002 ##1 !O_FLUSH)
        else $error("taken skip wrong");
    a_skip_not_taken: assert property (
        is_skip && !I_FILE_RDATA[I_INSTR[9:7]] |=> !O_FLUSH &&
        O_PC == $past(O_PC) + 13'h0001)
        else $error("untaken skip wrong");
    a_flush_holds_pc: assert property (
        O_FLUSH |=> $stable(O_PC) && !O_FILE_WR.we)
        else $error("discarded cycle had an effect");
    a_kick_sets_flags: assert property (
        taken && I_INSTR == `OPV_WDKICK |=> O_WATCHDOG_CLEAR &&
        O_WATCHDOG_EXPIRY_FLAG_N && O_SLEEP_FLAG_N)
        else $error("watchdog kick wrong");
    a_invert_result: assert property (
        is_inv |=> O_FILE_WR.we == $past(I_INSTR[`F_DEST_BIT]) &&
        (O_FILE_WR.we ? O_FILE_WR.data : O_ACCUM) ==
        ~$past(I_FILE_RDATA) && O_ZERO == ($past(I_FILE_RDATA) == 8'hFF))
        else $error("complement wrong");
    a_decr_result: assert property (
        is_dec |=> O_FILE_WR.we == $past(I_INSTR[`F_DEST_BIT]) &&
        (O_FILE_WR.we ? O_FILE_WR.data : O_ACCUM) ==
        $past(I_FILE_RDATA) - 8'h01 && O_ZERO == ($past(I_FILE_RDATA) == 8'h01))
        else $error("decrement wrong");
    a_file_zeroing: assert property (
        taken && (I_INSTR & `OPM_FIELD7) == `OPV_FZERO |=>
        O_FILE_WR == {1'b1, $past(I_INSTR[6:0]), 8'h00} && O_ZERO)
        else $error("file clear wrong");
    a_accum_zeroing: assert property (
        taken && (I_INSTR & `OPM_FIELD7) == `OPV_AZERO |=>
        O_ACCUM == 8'h00 && O_ZERO && !O_FILE_WR.we)
        else $error("accumulator clear wrong");
endmodule

// >>> verification/core_exec_subset_test.sv
/*
 * Self-checking bench of the core execute subset: instruction and
 * register-port sequences with expected values.
 * Assumes package, header and checker are compiled before it.
 */
`include "core_exec_cfg.svh"

module core_exec_subset_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic                     I_CLK = 1'b0;
    logic                     I_RST;
    logic                     I_INSTR_VALID;
    logic                     I_WDT_EXPIRED;
    logic                     I_SLEEP_ENTER;
    logic                     I_REG_WR;
    logic                     I_REG_RD;
    logic [`INSTR_W-1:0]      I_INSTR;
    logic [`DATA_W-1:0]       I_FILE_RDATA;
    logic [`RADDR_W-1:0]      I_REG_ADDR;
    logic [`RDATA_W-1:0]      I_REG_WDATA;
    logic [`RDATA_W-1:0]      O_REG_RDATA;
    logic [`FADDR_W-1:0]      O_FILE_RADDR;
    core_exec_pkg::file_wr_s  O_FILE_WR;
    logic [`PC_W-1:0]         O_PC;
    logic [`PC_W-1:0]         O_STACK_TOP;
    logic [`DATA_W-1:0]       O_ACCUM;
    logic                     O_ZERO;
    logic                     O_WATCHDOG_EXPIRY_FLAG_N;
    logic                     O_SLEEP_FLAG_N;
    logic                     O_WATCHDOG_CLEAR;
    logic                     O_FLUSH;
    logic [`PC_W-1:0]         pc_exp;
    int                       fails;
    int                       checks_done;
    int                       b;

    core_exec_subset uut (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_INSTR_VALID(I_INSTR_VALID),
        .I_INSTR(I_INSTR), .I_FILE_RDATA(I_FILE_RDATA),
        .I_WDT_EXPIRED(I_WDT_EXPIRED), .I_SLEEP_ENTER(I_SLEEP_ENTER),
        .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
        .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
        .O_REG_RDATA(O_REG_RDATA), .O_FILE_RADDR(O_FILE_RADDR),
        .O_FILE_WR(O_FILE_WR), .O_PC(O_PC), .O_STACK_TOP(O_STACK_TOP),
        .O_ACCUM(O_ACCUM), .O_ZERO(O_ZERO),
        .O_WATCHDOG_EXPIRY_FLAG_N(O_WATCHDOG_EXPIRY_FLAG_N),
        .O_SLEEP_FLAG_N(O_SLEEP_FLAG_N),
        .O_WATCHDOG_CLEAR(O_WATCHDOG_CLEAR), .O_FLUSH(O_FLUSH)
    );

    // 10 MHz clock
    always #50 I_CLK = ~I_CLK;

    ////////////////////////////////////////////////////////////////////////
    // Four-state compare so an unknown never passes
    task chk(input logic [15:0] got, input logic [15:0] exp,
             input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    // One word per edge; idle lets the last effect land before checking
    task put(input logic [13:0] w, input logic [7:0] rd);
        @(posedge I_CLK);
        I_INSTR_VALID <= 1'b1;
        I_INSTR       <= w;
        I_FILE_RDATA  <= rd;
    endtask

    task idle;
        @(posedge I_CLK);
        I_INSTR_VALID <= 1'b0;
        #1;
    endtask

    // Plain one-cycle operation; write field ignored while we is low
    task op(input logic [13:0] w, input logic [7:0] rd,
            input logic [7:0] acc, input logic [15:0] wr, input logic z);
        put(w, rd);
        idle();
        pc_exp = pc_exp + 13'h0001;
        chk(O_PC, pc_exp, "pc");
        chk(O_FILE_RADDR, 16'(w[6:0]), "file address");
        chk(O_ACCUM, acc, "accumulator");
        chk(O_FILE_WR.we ? O_FILE_WR : 16'h0000, wr, "file write");
        chk(O_ZERO, z, "zero flag");
    endtask

    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        I_REG_WR    <= 1'b1;
        I_REG_ADDR  <= a;
        I_REG_WDATA <= d;
        @(posedge I_CLK);
        I_REG_WR    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task reg_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge I_CLK);
        I_REG_RD   <= 1'b1;
        I_REG_ADDR <= a;
        @(posedge I_CLK);
        I_REG_RD   <= 1'b0;
        #1;
        chk(O_REG_RDATA, exp, "read data");
    endtask

    task close_out;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #100000;
        fails++;
        close_out();
    end

    initial begin
        {I_RST, I_INSTR_VALID, I_WDT_EXPIRED, I_SLEEP_ENTER} = 4'h8;
        {I_REG_WR, I_REG_RD, I_INSTR, I_FILE_RDATA} = 24'h000000;
        {I_REG_ADDR, I_REG_WDATA} = 20'h00000;
        pc_exp = 13'h0000;
        repeat (10) @(posedge I_CLK);
        I_RST <= 1'b0;
        #1;
        chk({O_FLUSH, O_SLEEP_FLAG_N, O_WATCHDOG_EXPIRY_FLAG_N, O_ZERO},
            16'h0006, "reset flags");
        chk(O_PC | O_STACK_TOP | O_FILE_WR, 16'h0000, "reset state");
        reg_rd(`REG_STATUS, 16'h0006);
        reg_rd(4'hF, 16'h0000);
        reg_wr(`REG_ACCUM, 16'h00FF);
        reg_rd(`REG_ACCUM, 16'h0000);
        // Arithmetic and clears, with boundary values
        op(`OPV_DECR | 14'h0005, 8'h00, 8'hFF, 16'h0000, 1'b0);
        op(`OPV_AZERO | 14'h007F, 8'h5A, 8'h00, 16'h0000, 1'b1);
        op(`OPV_INVERT | 14'h00FF, 8'hFF, 8'h00, 16'hFF00, 1'b1);
        op(`OPV_INVERT | 14'h0012, 8'h5A, 8'hA5, 16'h0000, 1'b0);
        op(`OPV_FZERO | 14'h007F, 8'h33, 8'hA5, 16'hFF00, 1'b1);
        op(`OPV_DECR | 14'h0081, 8'h01, 8'hA5, 16'h8100, 1'b1);
        op(`OPV_DECR | 14'h0080, 8'h80, 8'hA5, 16'h807F, 1'b0);
        op(14'h3FFF, 8'h00, 8'hA5, 16'h0000, 1'b0);
        // Pull both flags low, then kick
        @(posedge I_CLK);
        I_WDT_EXPIRED <= 1'b1;
        I_SLEEP_ENTER <= 1'b1;
        @(posedge I_CLK);
        I_WDT_EXPIRED <= 1'b0;
        I_SLEEP_ENTER <= 1'b0;
        #1;
        chk({O_WATCHDOG_EXPIRY_FLAG_N, O_SLEEP_FLAG_N}, 16'h0000, "flags");
        op(`OPV_WDKICK, 8'h00, 8'hA5, 16'h0000, 1'b0);
        chk({O_WATCHDOG_CLEAR, O_WATCHDOG_EXPIRY_FLAG_N, O_SLEEP_FLAG_N},
            16'h0007, "kick");
        // Every bit position, clear then set with a word behind it
        for (b = 0; b < 8; b++) begin
            op(`OPV_BITSKIP | 14'(b << 7) | 14'h0011, ~(8'h01 << b),
               8'hA5, 16'h0000, 1'b0);
            put(`OPV_BITSKIP | 14'(b << 7) | 14'h0011, 8'h01 << b);
            put(`OPV_AZERO, 8'h00);
            idle();
            pc_exp = pc_exp + 13'h0002;
            chk(O_PC, pc_exp, "skip pc");
            chk(O_ACCUM, 16'h00A5, "dropped word");
        end
        // Calls: only latch bits 4:3 reach the pc
        reg_wr(`REG_LATCH, 16'h000F);
        put(`OPV_CALL | 14'h0123, 8'h00);
        idle();
        chk(O_FLUSH, 16'h0001, "call flush");
        chk(O_PC, 16'h0923, "call target");
        chk(O_STACK_TOP, pc_exp + 13'h0001, "return address");
        reg_rd(`REG_LATCH, 16'h000F);
        reg_wr(`REG_LATCH, 16'h0018);
        put(`OPV_CALL | 14'h07FF, 8'h00);
        put(`OPV_AZERO, 8'h00);
        idle();
        chk(O_PC, 16'h1FFF, "call high");
        chk(O_STACK_TOP, 16'h0924, "second return");
        chk(O_ACCUM, 16'h00A5, "word after call");
        reg_rd(`REG_PC, 16'h1FFF);
        reg_rd(`REG_STACK_TOP, 16'h0924);
        // Reset in mid-run
        @(posedge I_CLK);
        I_RST <= 1'b1;
        repeat (2) @(posedge I_CLK);
        I_RST <= 1'b0;
        #1;
        chk(O_PC | O_STACK_TOP | O_ACCUM, 16'h0000, "second reset");
        close_out();
    end
endmodule

bind core_exec_subset core_exec_subset_properties props (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_INSTR_VALID(I_INSTR_VALID),
    .I_INSTR(I_INSTR), .I_FILE_RDATA(I_FILE_RDATA),
    .I_WDT_EXPIRED(I_WDT_EXPIRED), .I_SLEEP_ENTER(I_SLEEP_ENTER),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .O_FILE_RADDR(O_FILE_RADDR), .O_FILE_WR(O_FILE_WR), .O_PC(O_PC),
    .O_STACK_TOP(O_STACK_TOP), .O_ACCUM(O_ACCUM), .O_ZERO(O_ZERO),
    .O_WATCHDOG_EXPIRY_FLAG_N(O_WATCHDOG_EXPIRY_FLAG_N),
    .O_SLEEP_FLAG_N(O_SLEEP_FLAG_N),
    .O_WATCHDOG_CLEAR(O_WATCHDOG_CLEAR), .O_FLUSH(O_FLUSH)
);
